/* timer2_control_flags.sv */
// Timer 2 control flags: package of constants and the control flag block
// Behaviour
// - Counter overflow sets overflow flag, bit 7
// - Down-count capture match also sets overflow flag
// - Hardware sets overflow flag only outside baud use
// - Only software clears overflow flag; writes set/clear
// - Enabled trigger fall without down count, or down-count reload overflow outside baud use, sets external flag
// - Edge-set external flag held until software clears
// - External flag set requests timer two interrupt
// - Receive select bit 5 affects serial modes 1,3
// - Receive select picks timer1 or timer2 overflow
// - Receive select forces baud generator mode
package timer2_ctrl_pkg;

    // Register offsets on the plain register port
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] MODE_OFFSET = 8'h01;
    localparam logic [7:0] STATUS_OFFSET = 8'h02;
    localparam logic [7:0] MASK_OFFSET = 8'h03;

    // Field positions of the timer_two_control register
    localparam int OVF_BIT = 7;
    localparam int EXT_BIT = 6;
    localparam int RCLK_BIT = 5;
    localparam int TRANSMIT_CLOCK_SELECT_BIT = 4;
    localparam int EXEN_BIT = 3;
    localparam int RUN_BIT = 2;
    localparam int CNT_SEL_BIT = 1;
    localparam int CAP_SEL_BIT = 0;
    // Count of plain storage bits below the two flags
    localparam int CTRL_LOW_W = 6;

    // Field position of the mode register
    localparam int DOWN_COUNT_ENABLE_BIT = 0;

    // Event status bit positions
    localparam int EV_OVF_SET = 0;
    localparam int EV_EDGE = 1;
    localparam int EV_EXT_OVF = 2;
    localparam int EVENT_COUNT = 3;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic MODE_RESET = 1'b0;
    localparam logic [EVENT_COUNT-1:0] STATUS_RESET = 3'h0;
    localparam logic [EVENT_COUNT-1:0] MASK_RESET = 3'h0;

    // Serial port modes that take a variable baud rate
    localparam logic [1:0] SERIAL_MODE1 = 2'h1;
    localparam logic [1:0] SERIAL_MODE3 = 2'h3;

endpackage

`timescale 1ns/10ps

module timer2_control_flags import timer2_ctrl_pkg::*; #(
    parameter int DATA_W = 8 // Register port data width
) (
    input wire logic clock,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    // Counter core
    input wire logic counter_overflow,
    input wire logic counter_equals_capture,
    output logic capture_strobe,
    output logic reload_strobe,
    output logic baud_generator_mode,
    output logic counter_run,
    output logic counter_select,
    output logic capture_reload_select,
    output logic down_count_enable,
    // External trigger pin
    input wire logic timer_two_trigger_pin,
    // Serial port
    input wire logic [1:0] serial_mode,
    input wire logic timer_one_overflow,
    output logic receive_baud_tick,
    output logic transmit_baud_tick,
    // Interrupt logic
    input wire logic timer_two_int_enable,
    output logic timer_two_request,
    output logic irq
);

    // Overview: the two flags of the control register are the only bits
    // that hardware writes; the six select bits below them are plain
    // storage that software owns. A small event register beside them
    // gives software a sticky record of every hardware set, so a polling
    // routine can tell an overflow from a trigger edge after the fact.
    // Everything runs on the one system clock; the trigger pin and the
    // counter pulses are taken as already synchronous to it.

    // Refuse widths the control register cannot fit in
    if (DATA_W < 8) begin : g_width_check
        $error("DATA_W must be at least 8");
    end

    // The read concatenation assumes the flags sit just above the select bits
    if (CTRL_LOW_W != EXT_BIT || OVF_BIT != EXT_BIT + 1) begin : g_layout_check
        $error("control field layout does not match the read path");
    end

    // True for serial modes whose baud comes from a timer overflow
    function automatic logic variable_baud_mode(input logic [1:0] mode);
        variable_baud_mode = (mode == SERIAL_MODE1) || (mode == SERIAL_MODE3);
    endfunction

    // Reset synchroniser stages
    logic rst_meta_q;
    logic rstn_sync;

    // Release reset through two flip-flops; assertion stays asynchronous.
    // A release straight from the pin could land close to a clock edge
    // and leave half the flags out of reset for one cycle.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_meta_q <= 1'b0;
            rstn_sync <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rstn_sync <= rst_meta_q;
        end
    end

    // Control register fields
    logic ovf_flag_q;
    logic ovf_flag_d;
    logic ext_flag_q;
    logic ext_flag_d;
    logic [CTRL_LOW_W-1:0] ctrl_low_q; // Select bits below the two flags
    logic [CTRL_LOW_W-1:0] ctrl_low_d; // Next value of the select bits
    logic down_count_enable_q; // Down-count enable in the mode register
    logic down_count_enable_d;

    // Interrupt status and mask
    logic [EVENT_COUNT-1:0] status_q;
    logic [EVENT_COUNT-1:0] mask_q;
    logic [EVENT_COUNT-1:0] mask_d;
    logic [EVENT_COUNT-1:0] event_vec;

    // Read data register
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;

    // Address decode
    // Full eight-bit compare, so aliases of the four registers read zero
    wire sel_ctrl = (reg_addr == CTRL_OFFSET);
    wire sel_mode = (reg_addr == MODE_OFFSET);
    wire sel_status = (reg_addr == STATUS_OFFSET);
    wire sel_mask = (reg_addr == MASK_OFFSET);
    wire wr_ctrl = reg_write & sel_ctrl;
    wire wr_mode = reg_write & sel_mode;
    wire wr_mask = reg_write & sel_mask;
    wire rd_status = reg_read & sel_status;

    // Named control fields
    wire rclk = ctrl_low_q[RCLK_BIT];
    wire transmit_clock_select = ctrl_low_q[TRANSMIT_CLOCK_SELECT_BIT];
    wire exen = ctrl_low_q[EXEN_BIT];
    wire cap_sel = ctrl_low_q[CAP_SEL_BIT];

    // Falling edge on the external trigger pin
    // The detector resets to the idle level of the pulled-up pin, so
    // leaving reset never looks like an edge
    logic trigger_fall;

    falling_edge_detect #(
        .IDLE_LEVEL(1'b1)
    ) u_trigger_edge (
        .clock(clock),
        .rstn_sync(rstn_sync),
        .level_in(timer_two_trigger_pin),
        .fall_pulse(trigger_fall)
    );

    // Baud generator use whenever either clock select is set
    wire baud_use = rclk | transmit_clock_select;

    // Overflow and down-count capture match both count as overflow events
    // A match is ignored while counting up, where equality with the
    // capture value carries no meaning
    wire match_event = down_count_enable_q & counter_equals_capture;
    wire overflow_event = counter_overflow | match_event;

    // Overflow flag set only outside baud generator use
    wire ovf_hw_set = overflow_event & ~baud_use;

    // Edge acts only with the external enable and without down counting;
    // with down counting the pin steers direction in the counter core
    wire edge_event = trigger_fall & exen & ~down_count_enable_q;

    // Overflow sets the external flag in down-count reload use, outside baud use
    wire ext_ovf_event = counter_overflow & down_count_enable_q & ~cap_sel & ~baud_use;

    // Any hardware set of the external flag
    wire ext_hw_set = edge_event | ext_ovf_event;

    // Overflow flag next value: hardware set wins over a software clear.
    // Letting the write win would silently lose an overflow that lands
    // in the same cycle as the handler's clear.
    always_comb begin
        if (ovf_hw_set) begin
            ovf_flag_d = 1'b1;
        end else if (wr_ctrl) begin
            ovf_flag_d = reg_wdata[OVF_BIT];
        end else begin
            ovf_flag_d = ovf_flag_q; // Never cleared by hardware
        end
    end

    // External flag next value: held until software clears it
    always_comb begin
        if (ext_hw_set) begin
            ext_flag_d = 1'b1;
        end else if (wr_ctrl) begin
            ext_flag_d = reg_wdata[EXT_BIT];
        end else begin
            ext_flag_d = ext_flag_q; // Held set
        end
    end

    // Remaining control bits and mode register are plain storage
    assign ctrl_low_d = wr_ctrl ? reg_wdata[CTRL_LOW_W-1:0] : ctrl_low_q;
    assign down_count_enable_d = wr_mode ? reg_wdata[DOWN_COUNT_ENABLE_BIT] : down_count_enable_q;
    assign mask_d = wr_mask ? reg_wdata[EVENT_COUNT-1:0] : mask_q;

    // Control and mode registers
    always_ff @(posedge clock or negedge rstn_sync) begin
        if (!rstn_sync) begin
            ovf_flag_q <= CTRL_RESET[OVF_BIT];
            ext_flag_q <= CTRL_RESET[EXT_BIT];
            ctrl_low_q <= CTRL_RESET[CTRL_LOW_W-1:0];
            down_count_enable_q <= MODE_RESET;
        end else begin
            ovf_flag_q <= ovf_flag_d;
            ext_flag_q <= ext_flag_d;
            ctrl_low_q <= ctrl_low_d;
            down_count_enable_q <= down_count_enable_d;
        end
    end

    // Mask register
    // Mask bits gate only the block interrupt, never the sticky status
    always_ff @(posedge clock or negedge rstn_sync) begin
        if (!rstn_sync) begin
            mask_q <= MASK_RESET;
        end else begin
            mask_q <= mask_d;
        end
    end

    // Event vector feeding the sticky status bits
    assign event_vec[EV_OVF_SET] = ovf_hw_set;
    assign event_vec[EV_EDGE] = edge_event;
    assign event_vec[EV_EXT_OVF] = ext_ovf_event;

    // Sticky status bits; a read clears, but an event in the same cycle wins
    // A read that meets a new event leaves that bit set, so the event is
    // seen on the next read instead of being lost
    for (genvar i = 0; i < EVENT_COUNT; i++) begin : g_status
        logic bit_d;

        // Set wins over the read clear
        assign bit_d = event_vec[i] ? 1'b1 : (rd_status ? 1'b0 : status_q[i]);

        // One sticky bit
        always_ff @(posedge clock or negedge rstn_sync) begin
            if (!rstn_sync) begin
                status_q[i] <= STATUS_RESET[i];
            end else begin
                status_q[i] <= bit_d;
            end
        end
    end

    // Read data selection; unmapped addresses read as zero
    // Only a read strobe loads data; without one the port reads zero, so
    // a stale value never looks like a fresh answer
    always_comb begin
        rdata_d = '0;
        if (reg_read) begin
            if (sel_ctrl) begin
                rdata_d[OVF_BIT:0] = {ovf_flag_q, ext_flag_q, ctrl_low_q};
            end else if (sel_mode) begin
                rdata_d[DOWN_COUNT_ENABLE_BIT] = down_count_enable_q;
            end else if (sel_status) begin
                rdata_d[EVENT_COUNT-1:0] = status_q;
            end else if (sel_mask) begin
                rdata_d[EVENT_COUNT-1:0] = mask_q;
            end else begin
                rdata_d = '0;
            end
        end
    end

    // Read data register; holds only in the cycle after the strobe
    always_ff @(posedge clock or negedge rstn_sync) begin
        if (!rstn_sync) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // Capture or reload strobe on an accepted edge; none in baud use,
    // where the edge only sets the external flag
    assign capture_strobe = edge_event & cap_sel & ~baud_use;
    assign reload_strobe = edge_event & ~cap_sel & ~baud_use;

    // Mode outputs to the counter core
    // Baud use takes the counter away from capture and reload, so the
    // select seen by the core is forced low there
    assign baud_generator_mode = baud_use;
    assign counter_run = ctrl_low_q[RUN_BIT];
    assign counter_select = ctrl_low_q[CNT_SEL_BIT];
    assign capture_reload_select = cap_sel & ~baud_use; // Baud use overrides
    assign down_count_enable = down_count_enable_q;

    // Receive time base: select matters only for timer-based serial modes
    // The ticks are combinational so the serial port sees the overflow in
    // its own cycle; a registered copy would add a cycle of skew
    wire rx_from_t2 = rclk & variable_baud_mode(serial_mode);
    assign receive_baud_tick = rx_from_t2 ? counter_overflow : timer_one_overflow;

    // Transmit time base by the same choice
    wire tx_from_t2 = transmit_clock_select & variable_baud_mode(serial_mode);
    assign transmit_baud_tick = tx_from_t2 ? counter_overflow : timer_one_overflow;

    // Timer two interrupt request: level while either flag is set.
    // A software write of the external flag raises it just like an edge.
    // The enable gates only the request, never the flags themselves.
    assign timer_two_request = timer_two_int_enable & (ovf_flag_q | ext_flag_q);

    // Block interrupt: any unmasked sticky event
    // Level output; it drops when software reads the status register or clears the matching mask bit
    assign irq = |(status_q & mask_q);

endmodule

/* falling_edge_detect.sv */
// Falling-edge detector for a pin sampled on the system clock
`timescale 1ns/10ps

module falling_edge_detect #(
    parameter bit IDLE_LEVEL = 1'b1 // Level assumed before the first sample
) (
    input wire logic clock,
    input wire logic rstn_sync,
    input wire logic level_in,
    output logic fall_pulse
);

    // Previous sample of the pin
    logic prev_q;
    // Next value of the previous sample
    logic prev_d;

    // Next sample is simply the current pin level
    assign prev_d = level_in;

    // High for one cycle when the pin went from high to low
    assign fall_pulse = prev_q & ~level_in;

    // Sample register; resets to the idle level so reset causes no false edge
    always_ff @(posedge clock or negedge rstn_sync) begin
        if (!rstn_sync) begin
            prev_q <= IDLE_LEVEL;
        end else begin
            prev_q <= prev_d;
        end
    end

endmodule

/* timer2_flags_chk.sv */
// Checker of the timer 2 control flag outputs
`timescale 1ns/10ps

module timer2_flags_chk (
    input wire logic clock,
    input wire logic rstn,
    input wire logic reg_write,
    input wire logic counter_overflow,
    input wire logic counter_equals_capture,
    input wire logic capture_strobe,
    input wire logic reload_strobe,
    input wire logic baud_generator_mode,
    input wire logic capture_reload_select,
    input wire logic down_count_enable,
    input wire logic timer_two_trigger_pin,
    input wire logic [1:0] serial_mode,
    input wire logic timer_one_overflow,
    input wire logic receive_baud_tick,
    input wire logic timer_two_int_enable,
    input wire logic timer_two_request
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // Hardware set sources, seen one cycle before the request
    sequence s_ovf;
        counter_overflow && !baud_generator_mode;
    endsequence
    sequence s_eq;
        counter_equals_capture && down_count_enable && !baud_generator_mode;
    endsequence
    sequence s_edge;
        capture_strobe || reload_strobe;
    endsequence
    // Quiet cycle in baud use: no write and no trigger fall
    sequence s_quiet;
        baud_generator_mode && timer_two_int_enable && !timer_two_request
            && !reg_write && !$fell(timer_two_trigger_pin);
    endsequence
    AST_OVF_SET: assert property (s_ovf ##1 timer_two_int_enable |-> timer_two_request)
        else $error("overflow did not raise the request");
    AST_EQ_SET: assert property (s_eq ##1 timer_two_int_enable |-> timer_two_request)
        else $error("capture match did not raise the request");
    AST_BAUD_NOSET: assert property (s_quiet ##1 timer_two_int_enable
        |-> !timer_two_request)
        else $error("flag set by hardware in baud use");
    AST_HOLD: assert property (timer_two_request && !reg_write
        ##1 timer_two_int_enable |-> timer_two_request)
        else $error("flag cleared without a write");
    AST_EDGE_CAUSE: assert property (s_edge |-> $fell(timer_two_trigger_pin))
        else $error("strobe without a trigger fall");
    AST_EDGE_REQ: assert property (s_edge ##1 timer_two_int_enable
        |-> timer_two_request)
        else $error("trigger fall did not raise the request");
    AST_RX_MODE: assert property (!serial_mode[0]
        |-> receive_baud_tick == timer_one_overflow)
        else $error("receive tick not from timer 1 in modes 0 and 2");
    AST_RX_T1: assert property (!baud_generator_mode
        |-> receive_baud_tick == timer_one_overflow)
        else $error("receive tick not from timer 1");
    AST_BAUD_MODE: assert property (baud_generator_mode
        |-> !capture_reload_select && !(capture_strobe || reload_strobe))
        else $error("capture or reload active in baud use");
endmodule

bind timer2_control_flags timer2_flags_chk i_chk (.clock, .rstn, .reg_write, .counter_overflow,
    .counter_equals_capture, .capture_strobe, .reload_strobe, .baud_generator_mode,
    .capture_reload_select, .down_count_enable, .timer_two_trigger_pin, .serial_mode,
    .timer_one_overflow, .receive_baud_tick, .timer_two_int_enable, .timer_two_request);

/* trigger_partner.sv */
// Model of the trigger pin driver and the timer 1 baud source
`timescale 1ns/10ps

module trigger_partner (
    input wire logic clock,
    input wire logic fall_go,
    output logic pin,
    output logic t1_ovf
);
    logic [2:0] low_q = 3'h0; // Cycles left with the pin low
    logic [1:0] div_q = 2'h0; // Timer 1 overflow divider
    // Pulled-up pin, low only for a short pulse on request
    always @(posedge clock) begin
        if (fall_go) begin
            low_q <= 3'h3;
        end else if (low_q != 3'h0) begin
            low_q <= low_q - 3'h1;
        end
        div_q <= div_q + 2'h1;
    end
    assign pin = (low_q == 3'h0);
    // One overflow every four cycles, so ticks show both levels
    assign t1_ovf = (div_q == 2'h3);
endmodule

/* test_timer2_control_flags.sv */
// Testbench of the timer 2 control flag block
`timescale 1ns/10ps

module test_timer2_control_flags;
    import timer2_ctrl_pkg::*;
    logic clock = 1'b0, rstn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, fall_go = 1'b0;
    logic cnt_ovf = 1'b0, cnt_eq = 1'b0, int_en = 1'b0; // Counter and enable stimulus
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [1:0] serial_mode = 2'h0;
    logic pin, t1_ovf, rx_t, tx_t, req, irq, rel_s, cap_s, baud_m, crs, run_o, sel_o, down_count_enable_o;
    int error_cnt = 0, n_checks = 0;
    trigger_partner i_far (.clock, .fall_go, .pin, .t1_ovf);
    timer2_control_flags i_dut (.clock, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .counter_overflow(cnt_ovf), .counter_equals_capture(cnt_eq),
        .capture_strobe(cap_s), .reload_strobe(rel_s), .baud_generator_mode(baud_m),
        .counter_run(run_o), .counter_select(sel_o), .capture_reload_select(crs),
        .down_count_enable(down_count_enable_o),
        .timer_two_trigger_pin(pin), .serial_mode, .timer_one_overflow(t1_ovf),
        .receive_baud_tick(rx_t), .transmit_baud_tick(tx_t), .timer_two_int_enable(int_en),
        .timer_two_request(req), .irq);
    // Free-running system clock
    initial begin
        forever #10 clock = ~clock;
    end
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk(n, e, reg_rdata);
    endtask
    task automatic pulse(input logic o, input logic q);
        @(posedge clock);
        cnt_ovf <= o;
        cnt_eq <= q;
        @(posedge clock);
        cnt_ovf <= 1'b0;
        cnt_eq <= 1'b0;
    endtask
    task automatic t_ovf;
        for (int i = 0; i < 5; i++) rd(i[7:0], 8'h00, "reset or unmapped");
        pulse(1'b1, 1'b0);
        rd(CTRL_OFFSET, 8'h80, "ovf flag");
        chk("irq masked", 8'h00, {7'h0, irq});
        rd(STATUS_OFFSET, 8'h01, "status ovf");
        rd(STATUS_OFFSET, 8'h00, "status cleared");
        wr(CTRL_OFFSET, 8'h00);
        rd(CTRL_OFFSET, 8'h00, "ovf sw clear");
        wr(CTRL_OFFSET, 8'h80);
        rd(CTRL_OFFSET, 8'h80, "ovf sw set");
        // Overflow in the cycle of a clearing write: the set must win
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= CTRL_OFFSET;
        reg_wdata <= 8'h00;
        cnt_ovf <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        cnt_ovf <= 1'b0;
        rd(CTRL_OFFSET, 8'h80, "set beats clear");
        rd(STATUS_OFFSET, 8'h01, "status set");
        wr(CTRL_OFFSET, 8'h06);
        #1 chk("run and select", 8'h03, {6'h0, run_o, sel_o});
        wr(CTRL_OFFSET, 8'h00);
        $display("test overflow done");
    endtask
    task automatic t_eq;
        pulse(1'b0, 1'b1);
        rd(CTRL_OFFSET, 8'h00, "match without down_count_enable");
        wr(MODE_OFFSET, 8'h01);
        #1 chk("down_count_enable output", 8'h01, {7'h0, down_count_enable_o});
        pulse(1'b0, 1'b1);
        rd(CTRL_OFFSET, 8'h80, "match with down_count_enable");
        wr(CTRL_OFFSET, 8'h00);
        pulse(1'b1, 1'b0);
        rd(CTRL_OFFSET, 8'hC0, "ext by overflow");
        rd(STATUS_OFFSET, 8'h05, "status match and ext");
        wr(CTRL_OFFSET, 8'h00);
        wr(MODE_OFFSET, 8'h00);
        $display("test match done");
    endtask
    task automatic t_baud;
        wr(CTRL_OFFSET, 8'h21);
        serial_mode <= SERIAL_MODE1;
        @(posedge clock);
        cnt_ovf <= 1'b1;
        #1 chk("rx tick timer2", 8'h01, {7'h0, rx_t});
        chk("baud mode and select", 8'h02, {6'h0, baud_m, crs});
        @(posedge clock);
        cnt_ovf <= 1'b0;
        rd(CTRL_OFFSET, 8'h21, "no ovf in baud use");
        @(posedge clock);
        serial_mode <= 2'h0;
        repeat (4) begin
            @(posedge clock);
            #1 chk("rx tick mode 0", {7'h0, t1_ovf}, {7'h0, rx_t});
        end
        wr(CTRL_OFFSET, 8'h30);
        serial_mode <= SERIAL_MODE3;
        @(posedge clock);
        cnt_ovf <= 1'b1;
        #1 chk("rx tick mode 3", 8'h01, {7'h0, rx_t});
        chk("tx tick mode 3", 8'h01, {7'h0, tx_t});
        @(posedge clock);
        cnt_ovf <= 1'b0;
        wr(CTRL_OFFSET, 8'h10);
        pulse(1'b1, 1'b0);
        rd(CTRL_OFFSET, 8'h10, "no ovf with transmit select");
        wr(CTRL_OFFSET, 8'h00);
        $display("test baud done");
    endtask
    task automatic t_edge;
        int n;
        wr(CTRL_OFFSET, 8'h08);
        wr(MASK_OFFSET, 8'h07);
        @(posedge clock);
        fall_go <= 1'b1;
        @(posedge clock);
        fall_go <= 1'b0;
        #1 n = 0;
        // Bounded wait for the accepted trigger edge
        while (rel_s !== 1'b1 && n < 8) begin
            @(posedge clock);
            #1 n++;
        end
        chk("reload strobe", 8'h01, {7'h0, rel_s});
        if (n == 8) finish_test();
        rd(CTRL_OFFSET, 8'h48, "ext by edge");
        chk("irq and request", 8'h03, {6'h0, irq, req});
        repeat (5) @(posedge clock);
        rd(CTRL_OFFSET, 8'h48, "ext held");
        rd(STATUS_OFFSET, 8'h02, "status edge");
        @(posedge clock);
        #1 chk("irq cleared", 8'h00, {7'h0, irq});
        wr(CTRL_OFFSET, 8'h08);
        rd(CTRL_OFFSET, 8'h08, "ext sw clear");
        // Capture mode: the same edge now gives a capture strobe
        wr(CTRL_OFFSET, 8'h09);
        @(posedge clock);
        fall_go <= 1'b1;
        @(posedge clock);
        fall_go <= 1'b0;
        #1 chk("capture strobe", 8'h01, {7'h0, cap_s});
        wr(CTRL_OFFSET, 8'h00);
        #1 chk("request cleared", 8'h00, {7'h0, req});
        rd(STATUS_OFFSET, 8'h02, "status capture edge");
        wr(CTRL_OFFSET, 8'h40);
        #1 chk("request by sw set", 8'h01, {7'h0, req});
        @(posedge clock);
        int_en <= 1'b0;
        @(posedge clock);
        #1 chk("request disabled", 8'h00, {7'h0, req});
        $display("test edge done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Main sequence after a three-cycle reset
    initial begin
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        int_en <= 1'b1;
        repeat (2) @(posedge clock);
        t_ovf();
        t_eq();
        t_baud();
        t_edge();
        finish_test();
    end
    // Hang guard
    initial begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        finish_test();
    end
endmodule
